// *** bench/mfrp_link_assertions.sv ***
// Purpose: link pin checks between host and flash read port
// Assumes: one core clock, raw link pins sampled directly, not through the input filters
// Notes: instantiated beside the link interface in tb
`timescale 1ns/1ps
module mfrp_link_assertions
  import mfrp_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic burst_clk,
  input wire logic address_valid_n,
  input wire logic device_select_n,
  input wire logic write_strobe_n,
  input wire logic output_drive_n,
  input wire logic ready,
  input wire logic [BUS_W-1:0] host_bus_out,
  input wire logic host_bus_oe,
  input wire logic [BUS_W-1:0] dev_bus_out,
  input wire logic dev_bus_oe,
  input wire logic [BUS_W-1:0] muxed_addr_data_bus
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  // host side pin discipline
  a_write_stays_high: assert property (write_strobe_n)
    else $error("write strobe driven low");
  a_addr_on_bus: assert property (!address_valid_n && !device_select_n |-> host_bus_oe)
    else $error("address valid without address on bus");
  a_clk_idle_low: assert property (device_select_n |-> !burst_clk)
    else $error("burst clock high while deselected");
  a_latch_with_addr: assert property ($rose(address_valid_n) && !device_select_n |->
    $past(host_bus_oe))
    else $error("address released before latch edge");
  a_oe_after_latch: assert property ($fell(output_drive_n) |->
    address_valid_n && !device_select_n)
    else $error("output drive before address latched");
  // device side bus drive and ready
  a_no_bus_clash: assert property (!(host_bus_oe && dev_bus_oe))
    else $error("both ends drive the bus");
  a_drive_after_oe: assert property ($rose(dev_bus_oe) |->
    !output_drive_n && !$past(output_drive_n, 4))
    else $error("device drove bus without output drive");
  a_drive_released: assert property (output_drive_n [*8] |-> !dev_bus_oe)
    else $error("device still drives after output drive high");
  a_ready_idle_high: assert property (device_select_n [*8] |-> ready)
    else $error("ready low outside a burst");
  a_wait_holds_word: assert property ($fell(ready) && dev_bus_oe |->
    $stable(dev_bus_out) [*8])
    else $error("bus word changed during wait");
  a_word_on_rise: assert property ($rose(ready) && !device_select_n |->
    $past(burst_clk, 2) && $past(burst_clk, 4))
    else $error("burst word not tied to clock rise");

  // main scenarios seen
  c_async_drive: cover property ($rose(dev_bus_oe) && !burst_clk);
  c_wait_cycle: cover property ($fell(ready) && dev_bus_oe);
  c_latch: cover property ($rose(address_valid_n) && !device_select_n);
endmodule

// *** bench/tb.sv ***
// Purpose: self-checking bench, host and flash port joined by the link
// Assumes: inputs driven at falling edge, host makes the burst clock
// Notes: wait cycles measured as extra clock rises against an aligned run
`timescale 1ns/1ps
module tb;
  import mfrp_pkg::*;
  logic core_clk, rst_b, cfg_load, load_en, array_busy, dev_cfg_done, req, req_burst;
  logic [BUS_W-1:0] cfg_data, load_data, req_addr, cfg_value, rd_data;
  logic [7:0] load_addr, req_len;
  logic burst_active, busy, rd_valid, act_seen;
  logic [BUS_W-1:0] got[$];
  int bad_count, samples_checked, rises;

  mfrp_link_if link();
  mfrp_device u_mfrp_device (.core_clk(core_clk), .rst_b(rst_b), .link(link),
    .cfg_load(cfg_load), .cfg_data(cfg_data), .load_en(load_en), .load_addr(load_addr),
    .load_data(load_data), .array_busy(array_busy), .cfg_value(cfg_value),
    .burst_active(burst_active));
  mfrp_host u_mfrp_host (.core_clk(core_clk), .rst_b(rst_b), .link(link),
    .dev_cfg_done(dev_cfg_done), .req(req), .req_addr(req_addr), .req_burst(req_burst),
    .req_len(req_len), .busy(busy), .rd_data(rd_data), .rd_valid(rd_valid));
  mfrp_link_assertions u_mfrp_link_assertions (.core_clk(core_clk), .rst_b(rst_b),
    .burst_clk(link.burst_clk), .address_valid_n(link.address_valid_n),
    .device_select_n(link.device_select_n), .write_strobe_n(link.write_strobe_n),
    .output_drive_n(link.output_drive_n), .ready(link.ready),
    .host_bus_out(link.host_bus_out), .host_bus_oe(link.host_bus_oe),
    .dev_bus_out(link.dev_bus_out), .dev_bus_oe(link.dev_bus_oe),
    .muxed_addr_data_bus(link.muxed_addr_data_bus));

  // core clock and link clock rise counter
  initial begin
    core_clk = 0;
    forever #20 core_clk = ~core_clk;
  end
  always @(posedge link.burst_clk) rises++;

  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic cmp(string what, logic [15:0] exp, logic [15:0] seen);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [15:0] pat(logic [7:0] a);
    return {~a, a};
  endfunction

  // expected word address of beat i
  function automatic logic [7:0] wa(logic [1:0] w, logic [7:0] a, int i);
    if (w == WRAP_8) return {a[7:3], a[2:0] + 3'(i)};
    if (w == WRAP_16) return {a[7:4], a[3:0] + 4'(i)};
    return a + 8'(i);
  endfunction

  task automatic set_cfg(logic [15:0] v);
    @(negedge core_clk);
    cfg_data = v;
    cfg_load = 1;
    @(negedge core_clk);
    cfg_load = 0;
    @(negedge core_clk);
    cmp("cfg_value", v, cfg_value);
  endtask

  // one host request, words gathered until busy drops
  task automatic xfer(logic b, logic [15:0] a, logic [7:0] n);
    int t;
    got.delete();
    @(negedge core_clk);
    req = 1;
    req_burst = b;
    req_addr = a;
    req_len = n;
    rises = 0;
    act_seen = 1'b0;
    @(negedge core_clk);
    req = 0;
    for (t = 0; t < 20000 && busy === 1'b1; t++) begin
      @(negedge core_clk);
      if (rd_valid === 1'b1) got.push_back(rd_data);
      if (burst_active === 1'b1) act_seen = 1'b1;
    end
    cmp("transfer finished", 16'h0000, 16'(busy));
  endtask

  task automatic burst(logic [3:0] dc, logic [1:0] w, logic [7:0] a, logic [7:0] n,
                       output int r);
    int i;
    set_cfg({1'b0, dc, 9'h000, w});
    xfer(1'b1, {8'h00, a}, n);
    cmp("burst count", 16'(n), 16'(got.size()));
    cmp("burst active seen", 16'h0001, 16'(act_seen));
    cmp("burst active end", 16'h0000, 16'(burst_active));
    for (i = 0; i < got.size() && i < n; i++) begin
      cmp("burst word", pat(wa(w, a, i)), got[i]);
    end
    r = rises;
  endtask

  task automatic wait_pair(logic [3:0] dc, logic [1:0] w, logic [7:0] base, logic [7:0] a,
                           logic [7:0] n, int dw);
    int r0, r1;
    burst(dc, w, base, n, r0);
    burst(dc, w, a, n, r1);
    cmp("wait cycles", 16'(dw), 16'(r1 - r0));
    $display("test burst dc %0d mode %0d start %h done", dc, w, a);
  endtask

  task automatic async_read(logic [7:0] a, logic [15:0] exp);
    xfer(1'b0, {8'h00, a}, 8'h01);
    cmp("async count", 16'h0001, 16'(got.size()));
    cmp("async word", exp, got[0]);
    cmp("async no burst", 16'h0000, 16'(act_seen));
    $display("test async read %h done", a);
  endtask

  // burst asked before the dummy count is set: host must not start
  task automatic refused_burst();
    xfer(1'b1, 16'h0010, 8'h04);
    cmp("burst refused", 16'h0000, 16'(got.size()));
    $display("test refused burst done");
  endtask

  // burst clocking while async reads are selected: sequencer stays idle
  task automatic async_mode_burst();
    xfer(1'b1, 16'h0020, 8'h02);
    cmp("burst in async mode", 16'h0000, 16'(act_seen));
    $display("test async mode burst done");
  endtask

  // watchdog
  initial begin
    repeat (60000) @(posedge core_clk);
    bad_count++;
    close_out();
  end

  initial begin
    rst_b = 0;
    {cfg_load, load_en, array_busy, dev_cfg_done, req, req_burst} = '0;
    {cfg_data, load_data, req_addr, load_addr, req_len} = '0;
    repeat (16) @(posedge core_clk);
    @(negedge core_clk);
    rst_b = 1;
    repeat (8) @(negedge core_clk);
    cmp("cfg reset", CFG_RESET, cfg_value);
    $display("test reset config done");
    for (int a = 0; a < 256; a++) begin
      @(negedge core_clk);
      load_en = 1;
      load_addr = 8'(a);
      load_data = pat(8'(a));
    end
    @(negedge core_clk);
    load_en = 0;
    async_read(8'h42, pat(8'h42));
    array_busy = 1;
    async_read(8'h43, 16'hFFFF);
    array_busy = 0;
    refused_burst();
    dev_cfg_done = 1;
    wait_pair(4'hA, WRAP_CONT, 8'h10, 8'h13, 8'h0C, 3);
    wait_pair(4'hA, WRAP_CONT, 8'h00, 8'h78, 8'h10, 2);
    wait_pair(4'hA, WRAP_CONT, 8'h00, 8'h7B, 8'h10, 5);
    wait_pair(4'h9, WRAP_CONT, 8'h10, 8'h15, 8'h0C, 5);
    wait_pair(4'h9, WRAP_CONT, 8'h00, 8'h78, 8'h10, 1);
    wait_pair(4'h8, WRAP_CONT, 8'h10, 8'h17, 8'h0C, 7);
    wait_pair(4'h8, WRAP_CONT, 8'h00, 8'h78, 8'h10, 0);
    wait_pair(4'h7, WRAP_CONT, 8'h10, 8'h11, 8'h0C, 0);
    wait_pair(4'h7, WRAP_CONT, 8'h10, 8'h14, 8'h0C, 3);
    wait_pair(4'h6, WRAP_CONT, 8'h10, 8'h12, 8'h0C, 0);
    wait_pair(4'h6, WRAP_CONT, 8'h10, 8'h15, 8'h0C, 3);
    wait_pair(4'hA, WRAP_8, 8'h10, 8'h13, 8'h08, 0);
    wait_pair(4'hA, WRAP_16, 8'h10, 8'h13, 8'h10, 3);
    set_cfg(CFG_RESET);
    async_mode_burst();
    async_read(8'hC5, pat(8'hC5));
    close_out();
  end
endmodule

// *** rtl/mfrp_device.sv ***
// Purpose: flash read port, async reads and linear or wrapping bursts
// Assumes: all link pins sampled by core_clk through three flops
// Notes: config word loaded from the user side; array loaded likewise
`timescale 1ns/1ps
module mfrp_device
  import mfrp_pkg::*;
#(
  parameter int MEM_AW = 8
) (
  input wire logic core_clk,
  input wire logic rst_b,
  mfrp_link_if.dev_mp link,
  input wire logic cfg_load,
  input wire logic [BUS_W-1:0] cfg_data,
  input wire logic load_en,
  input wire logic [MEM_AW-1:0] load_addr,
  input wire logic [BUS_W-1:0] load_data,
  input wire logic array_busy,
  output logic [BUS_W-1:0] cfg_value,
  output logic burst_active
);
  if (MEM_AW < 7 || MEM_AW > BUS_W) begin : g_chk
    $error("MEM_AW must lie in 7..16");
  end

  logic [BUS_W-1:0] mem [0:(1<<MEM_AW)-1];
  logic [SYNC_W_DEV-1:0] s1_reg, s2_reg, s3_reg, q_reg;
  logic clk_d_reg, avd_d_reg;
  logic [BUS_W-1:0] cfg_reg;
  logic [BUS_W-1:0] async_addr_reg;
  mfrp_dev_state_type state_reg;
  logic [3:0] cnt_reg;
  logic [BUS_W-1:0] addr_cnt_reg;
  logic [2:0] start_k_reg;
  logic first_grp_reg;
  logic ready_reg;
  logic [BUS_W-1:0] dout_reg;

  logic clk_q, avd_q, ce_q, we_q, oe_q;
  logic [BUS_W-1:0] bus_q;
  logic clk_rise, avd_rise, burst_start;
  logic [3:0] dc;
  logic [1:0] wrap;
  logic [BUS_W-1:0] nxt;
  logic [3:0] gap, grp_wait, bnd_wait, waits;
  logic leave_grp, cross_bnd, present_now;
  logic [MEM_AW-1:0] present_idx;

  // pins at their idle levels: clock low, strobes high, bus pulled up
  localparam logic [SYNC_W_DEV-1:0] PIN_IDLE = {1'b0, 4'hF, {BUS_W{1'b1}}};

  // three-flop input sampling; change taken once stages 2 and 3 agree
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_reg <= PIN_IDLE; // no false select or edge after reset
      s2_reg <= PIN_IDLE;
      s3_reg <= PIN_IDLE;
      q_reg <= PIN_IDLE;
    end else begin
      s1_reg <= {link.burst_clk, link.address_valid_n, link.device_select_n,
                 link.write_strobe_n, link.output_drive_n, link.muxed_addr_data_bus};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      q_reg <= (s2_reg & s3_reg) | (q_reg & (s2_reg | s3_reg));
    end
  end

  assign clk_q = q_reg[20];
  assign avd_q = q_reg[19];
  assign ce_q = q_reg[18];
  assign we_q = q_reg[17];
  assign oe_q = q_reg[16];
  assign bus_q = q_reg[15:0];

  // edge detection on filtered pins
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      clk_d_reg <= 1'b0;
      avd_d_reg <= 1'b1;
    end else begin
      clk_d_reg <= clk_q;
      avd_d_reg <= avd_q;
    end
  end

  assign clk_rise = clk_q & ~clk_d_reg;
  assign avd_rise = avd_q & ~avd_d_reg;

  // config word; reset value selects async reads
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_reg <= CFG_RESET;
    end else if (cfg_load) begin
      cfg_reg <= cfg_data;
    end
  end

  assign dc = cfg_reg[CFG_DC_LSB +: CFG_DC_W];
  assign wrap = cfg_reg[CFG_WRAP_LSB +: CFG_WRAP_W];
  assign cfg_value = cfg_reg;
  assign burst_active = (state_reg != DV_IDLE);

  // array contents from the user side
  always_ff @(posedge core_clk) begin
    if (load_en) begin
      mem[load_addr] <= load_data;
    end
  end

  // async address capture on rise of address_valid_n
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      async_addr_reg <= '0;
    end else if (avd_rise && !ce_q && we_q && cfg_reg[CFG_ASYNC_BIT]) begin
      async_addr_reg <= bus_q;
    end
  end

  // burst start: clock rise with valid low and bursts enabled
  assign burst_start = clk_rise && !avd_q && !ce_q && we_q
                       && !cfg_reg[CFG_ASYNC_BIT];

  // wait cycle arithmetic
  always_comb begin
    unique case (wrap)
      WRAP_8: nxt = {addr_cnt_reg[15:3], addr_cnt_reg[2:0] + 3'h1};
      WRAP_16: nxt = {addr_cnt_reg[15:4], addr_cnt_reg[3:0] + 4'h1};
      default: nxt = addr_cnt_reg + 16'h0001;
    endcase
    gap = DC_FULL_WAIT - dc;
    if (dc >= DC_FULL_WAIT) begin
      grp_wait = {1'b0, start_k_reg};
    end else if ({1'b0, start_k_reg} > gap) begin
      grp_wait = {1'b0, start_k_reg} - gap;
    end else begin
      grp_wait = 4'h0;
    end
    if (dc >= DC_TWO_BND && dc <= DC_TWO_BND_MAX) begin
      bnd_wait = BND_WAIT_TWO;
    end else if (dc == DC_ONE_BND) begin
      bnd_wait = BND_WAIT_ONE;
    end else begin
      bnd_wait = 4'h0;
    end
    leave_grp = first_grp_reg && (addr_cnt_reg[2:0] == GRP_LAST);
    cross_bnd = (wrap == WRAP_CONT) && (addr_cnt_reg[6:0] == BND_LAST);
    if (wrap == WRAP_8) begin
      waits = 4'h0;
    end else begin
      waits = (leave_grp ? grp_wait : 4'h0) + (cross_bnd ? bnd_wait : 4'h0);
    end
    present_now = 1'b0;
    present_idx = addr_cnt_reg[MEM_AW-1:0];
    if (clk_rise && !ce_q) begin
      unique case (state_reg)
        DV_DUMMY, DV_WAIT: present_now = (cnt_reg <= 4'h1);
        DV_DATA: begin
          present_now = (waits == 4'h0);
          present_idx = nxt[MEM_AW-1:0];
        end
        DV_IDLE: present_now = 1'b0;
      endcase
    end
  end

  // burst sequencer
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= DV_IDLE;
      cnt_reg <= 4'h0;
      addr_cnt_reg <= '0;
      start_k_reg <= 3'h0;
      first_grp_reg <= 1'b0;
      ready_reg <= 1'b1;
    end else if (ce_q) begin
      state_reg <= DV_IDLE;
      ready_reg <= 1'b1;
    end else begin
      unique case (state_reg)
        DV_IDLE: begin
          if (burst_start) begin
            state_reg <= DV_DUMMY;
            cnt_reg <= dc;
            addr_cnt_reg <= bus_q;
            start_k_reg <= bus_q[2:0];
            first_grp_reg <= 1'b1;
            ready_reg <= 1'b0;
          end
        end
        DV_DUMMY, DV_WAIT: begin
          if (clk_rise) begin
            if (cnt_reg <= 4'h1) begin
              state_reg <= DV_DATA;
              ready_reg <= 1'b1;
            end else begin
              cnt_reg <= cnt_reg - 4'h1;
            end
          end
        end
        DV_DATA: begin
          if (clk_rise) begin
            addr_cnt_reg <= nxt;
            if (leave_grp) begin
              first_grp_reg <= 1'b0;
            end
            if (waits != 4'h0) begin
              state_reg <= DV_WAIT;
              cnt_reg <= waits;
              ready_reg <= 1'b0;
            end
          end
        end
      endcase
    end
  end

  // output word register
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      dout_reg <= '0;
    end else if (present_now) begin
      dout_reg <= mem[present_idx];
    end else if (cfg_reg[CFG_ASYNC_BIT]) begin
      dout_reg <= mem[async_addr_reg[MEM_AW-1:0]];
    end
  end

  // bus drive: selected, enabled, not writing, nothing pending
  assign link.dev_bus_out = dout_reg;
  assign link.dev_bus_oe = !ce_q && !oe_q && we_q && !array_busy
                           && (cfg_reg[CFG_ASYNC_BIT] ? avd_q
                               : (state_reg == DV_DATA || state_reg == DV_WAIT));
  assign link.ready = ready_reg;
endmodule

// *** rtl/mfrp_host.sv ***
// Purpose: host controller end of the muxed flash read port
// Assumes: device pins sampled through three flops; host makes burst clock
// Notes: one read request at a time, async or burst
`timescale 1ns/1ps
module mfrp_host
  import mfrp_pkg::*;
#(
  parameter int HALF_CYC = LINK_HALF_CYC
) (
  input wire logic core_clk,
  input wire logic rst_b,
  mfrp_link_if.host_mp link,
  input wire logic dev_cfg_done,
  input wire logic req,
  input wire logic [BUS_W-1:0] req_addr,
  input wire logic req_burst,
  input wire logic [7:0] req_len,
  output logic busy,
  output logic [BUS_W-1:0] rd_data,
  output logic rd_valid
);
  if (HALF_CYC < MIN_HALF_CYC || HALF_CYC > 127) begin : g_chk
    $error("HALF_CYC must lie in 8..127");
  end

  localparam logic [7:0] HALF_L = 8'(HALF_CYC);
  localparam logic [7:0] PER_L = 8'(2 * HALF_CYC);

  logic [SYNC_W_HOST-1:0] s1_reg, s2_reg, s3_reg, q_reg;
  mfrp_host_state_type state_reg;
  logic [7:0] tmr_reg, div_reg, len_reg, got_reg;
  logic run_reg, clk_reg;
  logic avd_n_reg, ce_n_reg, oe_n_reg, bus_oe_reg;
  logic [BUS_W-1:0] addr_reg;
  logic sample_pt, per_end, last_word;

  // three-flop sampling of ready and bus
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_reg <= '1; // ready idles high, bus pulled up
      s2_reg <= '1;
      s3_reg <= '1;
      q_reg <= '1;
    end else begin
      s1_reg <= {link.ready, link.muxed_addr_data_bus};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      q_reg <= (s2_reg & s3_reg) | (q_reg & (s2_reg | s3_reg));
    end
  end

  // burst clock divider, low while idle
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      div_reg <= 8'h00;
      clk_reg <= 1'b0;
    end else if (!run_reg || last_word) begin
      div_reg <= 8'h00;
      clk_reg <= 1'b0;
    end else begin
      div_reg <= (div_reg == PER_L - 8'h01) ? 8'h00 : div_reg + 8'h01;
      clk_reg <= (div_reg == HALF_L - 8'h01) ||
                 (clk_reg && div_reg != PER_L - 8'h01);
    end
  end

  assign sample_pt = run_reg && (div_reg == HALF_L - 8'h01);
  assign per_end = run_reg && (div_reg == PER_L - 8'h01);
  // last word taken: no further rise while select goes high
  assign last_word = (state_reg == HS_BDATA) && sample_pt && q_reg[BUS_W]
                     && (got_reg + 8'h01 == len_reg);

  // request sequencer
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= HS_IDLE;
      tmr_reg <= 8'h00;
      len_reg <= 8'h00;
      got_reg <= 8'h00;
      run_reg <= 1'b0;
      avd_n_reg <= 1'b1;
      ce_n_reg <= 1'b1;
      oe_n_reg <= 1'b1;
      bus_oe_reg <= 1'b0;
      addr_reg <= '0;
      rd_data <= '0;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= 1'b0;
      unique case (state_reg)
        HS_IDLE: begin
          if (req && (!req_burst || dev_cfg_done)) begin
            addr_reg <= req_addr;
            len_reg <= req_len;
            got_reg <= 8'h00;
            ce_n_reg <= 1'b0;
            avd_n_reg <= 1'b0;
            bus_oe_reg <= 1'b1;
            tmr_reg <= 8'(ADDR_HOLD_CYC);
            run_reg <= req_burst;
            state_reg <= req_burst ? HS_BSTART : HS_ADDR;
          end
        end
        HS_ADDR: begin
          tmr_reg <= tmr_reg - 8'h01;
          if (tmr_reg == 8'h01) begin
            avd_n_reg <= 1'b1;
            tmr_reg <= 8'(ADDR_HOLD_CYC);
            state_reg <= HS_LATCH;
          end
        end
        HS_LATCH: begin
          tmr_reg <= tmr_reg - 8'h01;
          if (tmr_reg == 8'h01) begin
            bus_oe_reg <= 1'b0;
            oe_n_reg <= 1'b0;
            tmr_reg <= 8'(ACCESS_CYC);
            state_reg <= HS_ACC;
          end
        end
        HS_ACC: begin
          tmr_reg <= tmr_reg - 8'h01;
          if (tmr_reg == 8'h01) begin
            rd_data <= q_reg[BUS_W-1:0];
            rd_valid <= 1'b1;
            ce_n_reg <= 1'b1;
            oe_n_reg <= 1'b1;
            tmr_reg <= 8'(DESEL_CYC);
            state_reg <= HS_DESEL;
          end
        end
        HS_BSTART: begin
          if (per_end) begin
            avd_n_reg <= 1'b1;
            bus_oe_reg <= 1'b0;
            oe_n_reg <= 1'b0;
            state_reg <= HS_BDATA;
          end
        end
        HS_BDATA: begin
          if (sample_pt && q_reg[BUS_W]) begin
            rd_data <= q_reg[BUS_W-1:0];
            rd_valid <= 1'b1;
            got_reg <= got_reg + 8'h01;
            if (got_reg + 8'h01 == len_reg) begin
              run_reg <= 1'b0;
              ce_n_reg <= 1'b1;
              oe_n_reg <= 1'b1;
              tmr_reg <= 8'(DESEL_CYC);
              state_reg <= HS_DESEL;
            end
          end
        end
        HS_DESEL: begin
          tmr_reg <= tmr_reg - 8'h01;
          if (tmr_reg == 8'h01) begin
            state_reg <= HS_IDLE;
          end
        end
        default: state_reg <= HS_IDLE;
      endcase
    end
  end

  // pin drive
  assign link.burst_clk = clk_reg;
  assign link.address_valid_n = avd_n_reg;
  assign link.device_select_n = ce_n_reg;
  assign link.write_strobe_n = 1'b1;
  assign link.output_drive_n = oe_n_reg;
  assign link.host_bus_out = addr_reg;
  assign link.host_bus_oe = bus_oe_reg;
  assign busy = (state_reg != HS_IDLE);
endmodule

// *** rtl/mfrp_link_if.sv ***
// Purpose: pins between host controller and flash read port
// Assumes: shared bus resolved here from both output enables
// Notes: undriven bus reads as all ones (pull-up)
`timescale 1ns/1ps
interface mfrp_link_if;
  import mfrp_pkg::*;
  logic burst_clk;
  logic address_valid_n;
  logic device_select_n;
  logic write_strobe_n;
  logic output_drive_n;
  logic ready;
  logic [BUS_W-1:0] host_bus_out;
  logic host_bus_oe;
  logic [BUS_W-1:0] dev_bus_out;
  logic dev_bus_oe;
  logic [BUS_W-1:0] muxed_addr_data_bus;

  // wire level from the two enables
  assign muxed_addr_data_bus = host_bus_oe ? host_bus_out :
                               dev_bus_oe ? dev_bus_out : {BUS_W{1'b1}};

  modport host_mp (
    output burst_clk, address_valid_n, device_select_n, write_strobe_n,
    output output_drive_n, host_bus_out, host_bus_oe,
    input ready, muxed_addr_data_bus
  );
  modport dev_mp (
    input burst_clk, address_valid_n, device_select_n, write_strobe_n,
    input output_drive_n, muxed_addr_data_bus,
    output ready, dev_bus_out, dev_bus_oe
  );
endinterface

// *** rtl/mfrp_pkg.sv ***
// Purpose: shared constants and types of the muxed flash read port
// Assumes: 16-bit word-addressed muxed bus, core clock 25 MHz
// Notes: config word layout and host timing constants
package mfrp_pkg;
  localparam int BUS_W = 16;
  localparam int SYNC_W_DEV = 21;
  localparam int SYNC_W_HOST = 17;
  // config word fields
  localparam int CFG_ASYNC_BIT = 15;
  localparam int CFG_DC_LSB = 11;
  localparam int CFG_DC_W = 4;
  localparam int CFG_WRAP_LSB = 0;
  localparam int CFG_WRAP_W = 2;
  localparam logic [15:0] CFG_RESET = 16'hD000;
  localparam logic [1:0] WRAP_CONT = 2'h0;
  localparam logic [1:0] WRAP_8 = 2'h1;
  localparam logic [1:0] WRAP_16 = 2'h2;
  // group and boundary masks
  localparam logic [2:0] GRP_LAST = 3'h7;
  localparam logic [6:0] BND_LAST = 7'h7F;
  localparam logic [3:0] DC_FULL_WAIT = 4'h8;
  localparam logic [3:0] DC_ONE_BND = 4'h9;
  localparam logic [3:0] DC_TWO_BND = 4'hA;
  localparam logic [3:0] DC_TWO_BND_MAX = 4'hD;
  localparam logic [3:0] BND_WAIT_ONE = 4'h1;
  localparam logic [3:0] BND_WAIT_TWO = 4'h2;
  // host timing, times in ns
  localparam int CORE_CLK_NS = 40;
  localparam int LINK_HALF_NS = 320;
  localparam int ADDR_HOLD_NS = 320;
  localparam int ACCESS_NS = 640;
  localparam int DESEL_NS = 320;
  localparam int LINK_HALF_CYC = (LINK_HALF_NS + CORE_CLK_NS - 1) / CORE_CLK_NS;
  localparam int ADDR_HOLD_CYC = (ADDR_HOLD_NS + CORE_CLK_NS - 1) / CORE_CLK_NS;
  localparam int ACCESS_CYC = (ACCESS_NS + CORE_CLK_NS - 1) / CORE_CLK_NS;
  localparam int DESEL_CYC = (DESEL_NS + CORE_CLK_NS - 1) / CORE_CLK_NS;
  localparam int MIN_HALF_CYC = 8;

  typedef enum logic [1:0] {
    DV_IDLE = 2'b00,
    DV_DUMMY = 2'b01,
    DV_DATA = 2'b10,
    DV_WAIT = 2'b11
  } mfrp_dev_state_type;

  typedef enum logic [2:0] {
    HS_IDLE = 3'b000,
    HS_ADDR = 3'b001,
    HS_LATCH = 3'b010,
    HS_ACC = 3'b011,
    HS_BSTART = 3'b100,
    HS_BDATA = 3'b101,
    HS_DESEL = 3'b110
  } mfrp_host_state_type;
endpackage
